// ### verilog/cks_startup_top.sv
// clock source select and start-up delay sequencer with register port
//
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "cks_map.svh"
//
// Contract
// R1 - source select 0110 or 0111 picks the low-frequency crystal; codes disagree nearby
// R2 - low-frequency crystal reset delay: 4 cycles, plus 4.1 ms or 65 ms
// R3 - low-frequency crystal wake waits 1K cycles on 0100, 32K on 0101
// R4 - select 0010 picks the 8.0 MHz calibrated RC oscillator
// R5 - factory calibration byte loads into the calibration register during reset
// R6 - software writes to the calibration register retune the RC oscillator
// R7 - reset time-out runs from the separate watchdog timebase, not the RC source
// R8 - RC source: wake 6 cycles; reset 14 cycles, plus 4.1 or 65 ms
// R9 - reset pin disabled stretches the 14-cycle delay to 14 cycles plus 4.1 ms
// R10 - shipped RC start-up select is 10, slow rising power with 65 ms
// R11 - shipped divide-by-eight fuse is programmed so the clock starts divided
// R12 - select 0011 picks the 128 kHz internal oscillator
// R13 - 128 kHz source: wake 6 cycles; reset 14 cycles, plus 4 or 64 ms
// R14 - select 0000 runs from the clock input pin at 0 to 20 MHz
// R15 - external clock: wake 6 cycles; reset 14 cycles, plus 4.1 or 65 ms
// R16 - outside clock must not jump more than 2% per cycle except in reset
// R17 - prescale select resets to 0011 with divide fuse programmed, else 0000
// R18 - internal reset holds until source cycles and millisecond time-out both elapse
module cks_startup_top #(
    parameter int unsigned T4P1_CYC = `CKS_US_TO_CYC(`CKS_T_4P1MS_US),
    parameter int unsigned T65_CYC = `CKS_US_TO_CYC(`CKS_T_65MS_US),
    parameter int unsigned T4_CYC = `CKS_US_TO_CYC(`CKS_T_4MS_US),
    parameter int unsigned T64_CYC = `CKS_US_TO_CYC(`CKS_T_64MS_US)
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire cks_pkg::cks_fuse_t fuses,
    input wire logic [7:0] factory_calibration,
    input wire logic clock_input_pin,
    input wire logic timer_oscillator_pin,
    input wire logic rc_osc_clk,
    input wire logic lf128_osc_clk,
    input wire logic wake_event,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic core_reset_n,
    output logic core_clock_run,
    output cks_pkg::cks_source_t selected_source,
    output logic [7:0] rc_calibration_register,
    output logic [3:0] prescale_select_field
);
    localparam int TW = `CKS_TIMEOUT_W;
    localparam int CW = `CKS_CYC_W;

    cks_pkg::cks_fuse_t fuse_reg;
    cks_pkg::cks_state_t state_reg;
    cks_pkg::cks_state_t state_next;
    cks_pkg::cks_source_t source_reg;
    cks_pkg::cks_source_t source_next;
    cks_pkg::cks_delay_t plan;
    logic core_reset_n_reg;
    logic core_reset_n_next;
    logic run_reg;
    logic run_next;
    logic [7:0] cal_reg;
    logic [7:0] cal_next;
    logic [3:0] prescale_reg;
    logic [3:0] prescale_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic wait_reg;
    logic wait_next;
    logic sleep_req;
    logic load_cycles;
    logic load_timeout;
    logic [CW-1:0] cycles_value;
    logic cycles_zero;
    logic timeout_zero;
    logic [3:0] edge_pulse;
    logic [3:0] edge_pins;
    logic source_tick;
    logic req;
    logic commit;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic cks_pkg::cks_source_t decode_source(input logic [3:0] sel);
        cks_pkg::cks_source_t src;
        // 0010 and codes with no source of their own fall back to the RC
        src = cks_pkg::CKS_SRC_RC; // [R4]
        if (sel == `CKS_SEL_EXT)
            src = cks_pkg::CKS_SRC_EXT; // [R14]
        else if (sel == `CKS_SEL_LF128)
            src = cks_pkg::CKS_SRC_LF128; // [R12]
        else if (sel[3:2] == `CKS_SEL_LFXTAL_HI)
            // 0100..0111 all run the watch crystal; bit 0 picks the wake count
            src = cks_pkg::CKS_SRC_LFXTAL; // [R1]
        return src;
    endfunction

    function automatic cks_pkg::cks_delay_t reset_plan(input cks_pkg::cks_fuse_t f);
        cks_pkg::cks_delay_t d;
        logic is_lf128;
        d.source_cycles = `CKS_RST_CK_STD; // [R8] [R13] [R15]
        d.timeout_cycles = '0;
        is_lf128 = (decode_source(f.source_select) == cks_pkg::CKS_SRC_LF128);
        if (decode_source(f.source_select) == cks_pkg::CKS_SRC_LFXTAL)
        begin
            d.source_cycles = `CKS_RST_CK_LFXTAL; // [R2]
        end
        case (f.startup_select)
            `CKS_SUT_BOD:
            begin
                // programmed reset pin needs time to enter programming mode
                if (f.reset_pin_disabled &&
                    (decode_source(f.source_select) != cks_pkg::CKS_SRC_LFXTAL))
                begin
                    d.timeout_cycles = TW'(T4P1_CYC); // [R9]
                end
            end
            `CKS_SUT_FAST:
            begin
                d.timeout_cycles = is_lf128 ? TW'(T4_CYC) : TW'(T4P1_CYC); // [R2] [R8] [R13]
            end
            `CKS_SUT_SLOW:
            begin
                // shipped RC setting lands here
                d.timeout_cycles = is_lf128 ? TW'(T64_CYC) : TW'(T65_CYC); // [R10] [R15]
            end
            // reserved code: take the longest delay as the safe side
            default:
                d.timeout_cycles = is_lf128 ? TW'(T64_CYC) : TW'(T65_CYC);
        endcase
        return d;
    endfunction

    function automatic logic [CW-1:0] wake_cycles(input logic [3:0] sel);
        logic [CW-1:0] n;
        n = `CKS_WAKE_CK_STD; // [R8] [R13] [R15]
        if (decode_source(sel) == cks_pkg::CKS_SRC_LFXTAL)
        begin
            n = sel[`CKS_SEL_WAKE_BIT] ? `CKS_WAKE_CK_32K : `CKS_WAKE_CK_1K; // [R3]
        end
        return n;
    endfunction

    // ----------------------------------------------------------------
    // source clock edges
    // ----------------------------------------------------------------
    assign edge_pins = {timer_oscillator_pin, lf128_osc_clk, rc_osc_clk, clock_input_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_sync
            cks_pin_sync u_sync (
                .clk_sys(clk_sys),
                .reset_n(reset_n),
                .pin_in(edge_pins[gi]),
                .rise_pulse(edge_pulse[gi])
            );
        end
    endgenerate

    // source enum order matches the edge_pins order
    assign source_tick = edge_pulse[source_reg];

    // ----------------------------------------------------------------
    // delay counters
    // ----------------------------------------------------------------
    assign plan = reset_plan(fuse_reg);

    cks_down_counter #(
        .WIDTH(CW)
    ) u_cycles (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .load(load_cycles),
        .load_value(cycles_value),
        .tick(source_tick),
        .zero(cycles_zero)
    );

    // time-out ticks on the independent timebase whatever source runs the core
    cks_down_counter #(
        .WIDTH(TW)
    ) u_timeout (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .load(load_timeout),
        .load_value(plan.timeout_cycles),
        .tick(1'b1), // [R7]
        .zero(timeout_zero)
    );

    // ----------------------------------------------------------------
    // start-up sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        source_next = source_reg;
        core_reset_n_next = core_reset_n_reg;
        run_next = run_reg;
        load_cycles = 1'b0;
        load_timeout = 1'b0;
        cycles_value = plan.source_cycles;
        case (state_reg)
            cks_pkg::ST_LOAD:
            begin
                source_next = decode_source(fuse_reg.source_select);
                load_cycles = 1'b1;
                load_timeout = 1'b1;
                state_next = cks_pkg::ST_DELAY;
            end
            cks_pkg::ST_DELAY:
            begin
                if (cycles_zero && timeout_zero)
                begin
                    core_reset_n_next = 1'b1; // [R18]
                    run_next = 1'b1;
                    state_next = cks_pkg::ST_RUN;
                end
            end
            cks_pkg::ST_RUN:
            begin
                if (sleep_req)
                begin
                    run_next = 1'b0;
                    state_next = cks_pkg::ST_SLEEP;
                end
            end
            cks_pkg::ST_SLEEP:
            begin
                if (wake_event)
                begin
                    load_cycles = 1'b1;
                    cycles_value = wake_cycles(fuse_reg.source_select); // [R3]
                    state_next = cks_pkg::ST_WAKE;
                end
            end
            cks_pkg::ST_WAKE:
            begin
                if (cycles_zero)
                begin
                    run_next = 1'b1;
                    state_next = cks_pkg::ST_RUN;
                end
            end
            default:
            begin
                state_next = cks_pkg::ST_LOAD;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    // one wait cycle per access: data is formed on the first edge,
    // waitrequest drops in the next cycle and the write lands there
    assign req = avs_read || avs_write;
    assign commit = req && !wait_reg;
    assign sleep_req = commit && avs_write && (avs_address == `CKS_ADDR_CONTROL) &&
        avs_byteenable[0] && avs_writedata[`CKS_CTRL_SLEEP_BIT];

    always_comb
    begin
        wait_next = !(req && wait_reg);
        cal_next = cal_reg;
        prescale_next = prescale_reg;
        rdata_next = rdata_reg;
        if (req && wait_reg && avs_read)
        begin
            case (avs_address)
                `CKS_ADDR_CAL: rdata_next = {24'h000000, cal_reg};
                `CKS_ADDR_PRESCALE: rdata_next = {28'h0000000, prescale_reg};
                `CKS_ADDR_STATUS: rdata_next = {20'h00000, fuse_reg.source_select,
                    fuse_reg.startup_select, core_reset_n_reg, state_reg, source_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
        if (commit && avs_write && avs_byteenable[0])
        begin
            // trim takes effect on the oscillator at once
            if (avs_address == `CKS_ADDR_CAL)
                cal_next = avs_writedata[7:0]; // [R6]
            if (avs_address == `CKS_ADDR_PRESCALE)
                prescale_next = avs_writedata[3:0];
        end
    end

    // ----------------------------------------------------------------
    // state registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            // fuses are straps: caught while reset is held, then frozen
            fuse_reg <= fuses;
            state_reg <= cks_pkg::ST_LOAD;
            source_reg <= cks_pkg::CKS_SRC_RC;
            core_reset_n_reg <= 1'b0; // [R18]
            run_reg <= 1'b0;
            cal_reg <= factory_calibration; // [R5]
            // divided start protects parts whose source outruns the core
            prescale_reg <= fuses.div8_programmed ?
                `CKS_PRESCALE_DIV8 : `CKS_PRESCALE_DIV1; // [R11] [R17]
            rdata_reg <= 32'h00000000;
            wait_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            source_reg <= source_next;
            core_reset_n_reg <= core_reset_n_next;
            run_reg <= run_next;
            cal_reg <= cal_next;
            prescale_reg <= prescale_next;
            rdata_reg <= rdata_next;
            wait_reg <= wait_next;
        end
    end

    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign core_reset_n = core_reset_n_reg;
    assign core_clock_run = run_reg;
    assign selected_source = source_reg;
    assign rc_calibration_register = cal_reg;
    assign prescale_select_field = prescale_reg;
endmodule

// ### verilog/cks_map.svh
// constants for clock source selection and start-up sequencing
`ifndef CKS_MAP_SVH
`define CKS_MAP_SVH

// ----------------------------------------------------------------
// clock rate and time-outs
// ----------------------------------------------------------------
`define CKS_CLK_KHZ 40000
`define CKS_T_4P1MS_US 4100
`define CKS_T_65MS_US 65000
`define CKS_T_4MS_US 4000
`define CKS_T_64MS_US 64000
// whole cycles per microsecond keeps the product below 2**31
`define CKS_US_TO_CYC(us) ((us) * (`CKS_CLK_KHZ / 1000))
`define CKS_TIMEOUT_W 22

// ----------------------------------------------------------------
// fuse codes
// ----------------------------------------------------------------
`define CKS_SEL_EXT 4'h0
`define CKS_SEL_LF128 4'h3
`define CKS_SEL_LFXTAL_HI 2'h1
`define CKS_SEL_WAKE_BIT 0
`define CKS_SUT_BOD 2'h0
`define CKS_SUT_FAST 2'h1
`define CKS_SUT_SLOW 2'h2

// ----------------------------------------------------------------
// source cycle counts
// ----------------------------------------------------------------
`define CKS_CYC_W 16
`define CKS_RST_CK_LFXTAL 16'h0004
`define CKS_RST_CK_STD 16'h000E
`define CKS_WAKE_CK_STD 16'h0006
`define CKS_WAKE_CK_1K 16'h0400
`define CKS_WAKE_CK_32K 16'h8000

// ----------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------
`define CKS_ADDR_CAL 4'h0
`define CKS_ADDR_PRESCALE 4'h4
`define CKS_ADDR_CONTROL 4'h8
`define CKS_ADDR_STATUS 4'hC
`define CKS_CTRL_SLEEP_BIT 0
`define CKS_PRESCALE_DIV8 4'h3
`define CKS_PRESCALE_DIV1 4'h0

`endif

// ### verilog/cks_pkg.sv
// types for clock source selection and start-up sequencing
package cks_pkg;

    typedef enum logic [1:0] {
        CKS_SRC_EXT,
        CKS_SRC_RC,
        CKS_SRC_LF128,
        CKS_SRC_LFXTAL
    } cks_source_t;

    typedef enum logic [2:0] {
        ST_LOAD,
        ST_DELAY,
        ST_RUN,
        ST_SLEEP,
        ST_WAKE
    } cks_state_t;

    // fuse flags are high when the fuse is programmed
    typedef struct packed {
        logic [3:0] source_select;
        logic [1:0] startup_select;
        logic div8_programmed;
        logic reset_pin_disabled;
    } cks_fuse_t;

    typedef struct packed {
        logic [15:0] source_cycles;
        logic [21:0] timeout_cycles;
    } cks_delay_t;

endpackage

// ### verilog/cks_pin_sync.sv
// three-stage synchroniser that reports rising edges of an outside level
`timescale 1ns/10ps
module cks_pin_sync (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic pin_in,
    output logic rise_pulse
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic stable_reg;
    logic stable_next;

    // ----------------------------------------------------------------
    // agreement filter
    // ----------------------------------------------------------------
    // s1 feeds only s2; a change counts once s2 and s3 agree
    always_comb
    begin
        stable_next = stable_reg;
        if (s2_reg == s3_reg)
        begin
            stable_next = s3_reg;
        end
        rise_pulse = (s2_reg == s3_reg) && s3_reg && !stable_reg;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            stable_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            stable_reg <= stable_next;
        end
    end
endmodule

// ### verilog/cks_down_counter.sv
// loadable down counter that stops at zero
`timescale 1ns/10ps
module cks_down_counter #(
    parameter int WIDTH = 16
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    input wire logic tick,
    output logic zero
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    always_comb
    begin
        count_next = count_reg;
        if (load)
        begin
            count_next = load_value;
        end
        else if (tick && (count_reg != '0))
        begin
            count_next = count_reg - WIDTH'(1);
        end
        zero = (count_reg == '0);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            count_reg <= '0;
        end
        else
        begin
            count_reg <= count_next;
        end
    end
endmodule

// ### verif/cks_osc_model.sv
// free-running source oscillator standing in for the crystal or clock generator
`timescale 1ns/10ps
module cks_osc_model (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] half_cycles,
    output logic osc_level
);
    // ----------------------------------------------------------------
    // oscillator
    // ----------------------------------------------------------------
    logic [7:0] half_reg = 8'h01;
    logic [7:0] cnt_reg = 8'h00;
    logic lvl_reg = 1'b0;
    // period may only move while the device sits in reset
    always @(posedge clk_sys)
    begin
        if (!reset_n)
            half_reg <= half_cycles;
        if (cnt_reg + 8'h01 >= half_reg)
        begin
            cnt_reg <= 8'h00;
            lvl_reg <= ~lvl_reg;
        end
        else
            cnt_reg <= cnt_reg + 8'h01;
    end
    // runs free like a real crystal, so no idle level exists
    assign osc_level = lvl_reg;
endmodule

// ### verif/cks_startup_checker.sv
// concurrent checks on the start-up sequencer ports
`timescale 1ns/10ps
module cks_startup_checker #(
    parameter int unsigned T4P1_CYC = 40,
    parameter int unsigned T65_CYC = 60,
    parameter int unsigned T4_CYC = 30,
    parameter int unsigned T64_CYC = 50
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire cks_pkg::cks_fuse_t fuses,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic core_reset_n,
    input wire logic core_clock_run,
    input wire cks_pkg::cks_source_t selected_source,
    input wire logic [7:0] rc_calibration_register,
    input wire logic [3:0] prescale_select_field
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    logic [16:0] up_reg;
    logic [16:0] up_next;
    always_comb up_next = (up_reg == 17'h1FFFF) ? up_reg : up_reg + 17'h00001;
    always_ff @(posedge clk_sys) up_reg <= reset_n ? up_next : 17'h00000;
    function automatic cks_pkg::cks_source_t src_of(input logic [3:0] s);
        if (s == 4'h0) return cks_pkg::CKS_SRC_EXT;
        if (s == 4'h3) return cks_pkg::CKS_SRC_LF128;
        if (s[3:2] == 2'b01) return cks_pkg::CKS_SRC_LFXTAL;
        return cks_pkg::CKS_SRC_RC;
    endfunction
    function automatic int unsigned tmo_of(input cks_pkg::cks_fuse_t f);
        logic slow;
        slow = (f.source_select == 4'h3);
        if (f.startup_select == 2'h0)
            return (f.reset_pin_disabled && f.source_select[3:2] != 2'b01) ? T4P1_CYC : 0;
        if (f.startup_select == 2'h1) return slow ? T4_CYC : T4P1_CYC;
        return slow ? T64_CYC : T65_CYC;
    endfunction
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest not low one cycle after a request");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_unmapped_zero: assert property (avs_read && avs_waitrequest
        && (avs_address[1:0] != 2'h0 || avs_address == 4'h8) |=> avs_readdata == 32'h0)
        else $error("unmapped or write-only read not zero");
    a_cal_write: assert property (avs_write && !avs_waitrequest && avs_address == 4'h0
        && avs_byteenable[0] |=> rc_calibration_register == $past(avs_writedata[7:0]))
        else $error("trim write did not land");
    a_cal_read: assert property (avs_read && avs_waitrequest && avs_address == 4'h0
        |=> avs_readdata == {24'h000000, $past(rc_calibration_register)})
        else $error("trim read back wrong");
    a_src_decode: assert property ($rose(reset_n) |=> selected_source == src_of(fuses.source_select))
        else $error("source decode wrong");
    a_timeout_min: assert property ($rose(core_reset_n) |-> {15'h0000, up_reg} >= tmo_of(fuses))
        else $error("internal reset released before time-out");
    a_presc_reset: assert property ($rose(reset_n)
        |-> prescale_select_field == (fuses.div8_programmed ? 4'h3 : 4'h0))
        else $error("prescale reset value wrong");
    a_run_gated: assert property (core_clock_run |-> core_reset_n)
        else $error("core clock runs during internal reset");
    a_sleep_stop: assert property (avs_write && !avs_waitrequest && avs_address == 4'h8
        && avs_byteenable[0] && avs_writedata[0] && core_clock_run |=> !core_clock_run)
        else $error("sleep write did not stop the core clock");
endmodule
bind cks_startup_top cks_startup_checker #(.T4P1_CYC(T4P1_CYC), .T65_CYC(T65_CYC),
    .T4_CYC(T4_CYC), .T64_CYC(T64_CYC)) u_checker (.*);

// ### verif/cks_startup_top_bench.sv
// self-checking bench for the clock source select and start-up sequencer
`timescale 1ns/10ps
`include "cks_map.svh"
module cks_startup_top_bench;
    // ----------------------------------------------------------------
    // stimulus and harness
    // ----------------------------------------------------------------
    // short time-outs keep the run small; expectations follow them
    localparam int T4P1 = 40;
    localparam int T65 = 60;
    localparam int T4 = 30;
    localparam int T64 = 50;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    cks_pkg::cks_fuse_t fuses = 8'h00;
    logic [7:0] factory_calibration = 8'h00;
    logic osc;
    logic wake_event = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic core_reset_n;
    logic core_clock_run;
    cks_pkg::cks_source_t selected_source;
    logic [7:0] rc_calibration_register;
    logic [3:0] prescale_select_field;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] boot_tab [17] = '{8'h00, 8'h06, 8'h08, 8'h01, 8'h20, 8'h24, 8'h2A, 8'h21,
        8'h2C, 8'h30, 8'h34, 8'h38, 8'h31, 8'h60, 8'h64, 8'h68, 8'h71};
    initial forever #12.5 clk_sys = ~clk_sys;
    // one oscillator feeds every source pin so any selection sees edges
    cks_osc_model u_osc (.clk_sys(clk_sys), .reset_n(reset_n), .half_cycles(8'h02),
        .osc_level(osc));
    cks_startup_top #(.T4P1_CYC(T4P1), .T65_CYC(T65), .T4_CYC(T4), .T64_CYC(T64)) uut (
        .clock_input_pin(osc), .timer_oscillator_pin(osc), .rc_osc_clk(osc),
        .lf128_osc_clk(osc), .*);
    task automatic final_report();
        if (miscompares == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            final_report();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] q);
        @(posedge clk_sys);
        avs_read <= ~wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk_sys);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    function automatic int tmo_of(input logic [7:0] f);
        if (f[3:2] == 2'h0) return (f[0] && f[7:6] != 2'b01) ? T4P1 : 0;
        if (f[3:2] == 2'h1) return (f[7:4] == 4'h3) ? T4 : T4P1;
        return (f[7:4] == 4'h3) ? T64 : T65;
    endfunction
    function automatic logic [1:0] src_of(input logic [3:0] s);
        if (s == 4'h0) return 2'h0;
        if (s == 4'h3) return 2'h2;
        if (s[3:2] == 2'b01) return 2'h3;
        return 2'h1;
    endfunction
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic boot(input logic [7:0] f, input logic [7:0] cal);
        int k;
        int lo;
        logic [31:0] q;
        @(posedge clk_sys);
        reset_n <= 1'b0;
        fuses <= f;
        factory_calibration <= cal;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        k = 0;
        lo = (f[7:6] == 2'b01) ? 16 : 56;
        if (tmo_of(f) > lo)
            lo = tmo_of(f);
        while (core_reset_n !== 1'b1 && k < 400)
        begin
            @(posedge clk_sys);
            k++;
        end
        check(32'(k >= lo && k <= lo + 12), 32'h1);
        check({30'h0, selected_source}, {30'h0, src_of(f[7:4])});
        check({28'h0, prescale_select_field}, f[1] ? 32'h3 : 32'h0);
        check({24'h0, rc_calibration_register}, {24'h0, cal});
        bus(1'b0, `CKS_ADDR_STATUS, 32'h0, 4'hF, q);
        check(q, {20'h0, f[7:2], 1'b1, 3'h2, src_of(f[7:4])});
    endtask
    task automatic reg_access();
        logic [31:0] q;
        bus(1'b1, `CKS_ADDR_CAL, 32'h0000_003C, 4'h1, q);
        bus(1'b1, `CKS_ADDR_CAL, 32'h0000_0055, 4'h0, q);
        bus(1'b0, `CKS_ADDR_CAL, 32'h0, 4'hF, q);
        check(q, 32'h3C);
        check({24'h0, rc_calibration_register}, 32'h3C);
        bus(1'b1, `CKS_ADDR_PRESCALE, 32'hFFFF_FFF8, 4'h1, q);
        bus(1'b0, `CKS_ADDR_PRESCALE, 32'h0, 4'hF, q);
        check(q, 32'h8);
        bus(1'b1, 4'h6, 32'hFFFF_FFFF, 4'hF, q);
        bus(1'b0, 4'h6, 32'h0, 4'hF, q);
        check(q, 32'h0);
        bus(1'b0, `CKS_ADDR_CONTROL, 32'h0, 4'hF, q);
        check(q, 32'h0);
    endtask
    task automatic sleep_wake(input logic [7:0] f, input int n);
        int k;
        logic [31:0] q;
        boot(f, 8'h80);
        wake_event <= 1'b1;
        @(posedge clk_sys);
        wake_event <= 1'b0;
        bus(1'b1, `CKS_ADDR_CONTROL, 32'h1, 4'h1, q);
        repeat (2) @(posedge clk_sys);
        check({31'h0, core_clock_run}, 32'h0);
        wake_event <= 1'b1;
        @(posedge clk_sys);
        wake_event <= 1'b0;
        k = 0;
        while (core_clock_run !== 1'b1 && k < 5000)
        begin
            @(posedge clk_sys);
            k++;
        end
        check(32'(n > 1200 ? k == 5000 : k + 4 >= 4*n && k <= 4*n + 12), 1);
    endtask
    initial
    begin
        repeat (4) @(posedge clk_sys);
        for (int i = 0; i < 17; i++)
            boot(boot_tab[i], 8'h40 + 8'(i));
        reg_access();
        sleep_wake(8'h20, 6);
        sleep_wake(8'h30, 6);
        sleep_wake(8'h00, 6);
        sleep_wake(8'h40, 1024);
        sleep_wake(8'h50, 32768);
        final_report();
    end
endmodule
